// ===== core/scm_pkg.sv
// Purpose: Shared constants for the secure-channel management terminal controller
// Assumes: Byte-wide card link, classic Wishbone register port
// Notes:   Offsets are byte addresses on the register bus
package scm_pkg;

  // Register map
  localparam int          ADR_W          = 9;
  localparam logic [8:0]  ADR_CTRL       = 9'h000;
  localparam logic [8:0]  ADR_STATUS     = 9'h004;
  localparam logic [8:0]  ADR_ALG        = 9'h008;
  localparam logic [8:0]  ADR_SIZE       = 9'h00C;
  localparam logic [8:0]  ADR_CLA_INS    = 9'h010;
  localparam logic [8:0]  ADR_SESS       = 9'h014;
  localparam logic [8:0]  ADR_BUF        = 9'h100;

  // Reset values
  localparam logic [7:0]  CLA_RST        = 8'h00;
  localparam logic [7:0]  INS_RST        = 8'h00;
  localparam logic [7:0]  BYTE_RST       = 8'h00;

  // Command frame codes
  localparam logic [7:0]  P1_START       = 8'h03;
  localparam logic [7:0]  P1_TERM        = 8'h04;
  localparam logic [7:0]  P2_CMD         = 8'h80;
  localparam logic [7:0]  P2_RSP         = 8'hA0;
  localparam logic [7:0]  TAG_CMD        = 8'h73;
  localparam logic [7:0]  TAG_START_RSP  = 8'h53;
  localparam logic [7:0]  TAG_ALG        = 8'h89;
  localparam logic [7:0]  TAG_MSA        = 8'h88;
  localparam logic [7:0]  TAG_CSA        = 8'h8B;
  localparam logic [7:0]  TAG_MAC        = 8'h8D;
  localparam logic [7:0]  TAG_SIZE       = 8'h8E;
  localparam logic [7:0]  LEN_ALG        = 8'h02;
  localparam logic [7:0]  LEN_ID         = 8'h10;
  localparam logic [7:0]  LEN_SIZE       = 8'h01;
  localparam logic [7:0]  LEN_OBJ        = 8'h20;
  localparam logic [7:0]  START_BODY     = 8'h2B;
  localparam logic [7:0]  START_RSP_LE   = 8'h03;
  localparam logic [7:0]  START_RSP_LEN  = 8'h01;
  localparam int          OBJ_TLV        = 34;
  localparam int          OBJ_BYTES      = 32;
  localparam int          ID_BYTES       = 16;
  localparam int          HDR_BYTES      = 7;
  localparam logic [7:0]  FETCH_LEN      = 8'h05;

  // Status words
  localparam logic [7:0]  SW1_OK         = 8'h90;
  localparam logic [7:0]  SW2_OK         = 8'h00;
  localparam logic [7:0]  SW1_MAC_BAD    = 8'h98;
  localparam logic [7:0]  SW2_MAC_BAD    = 8'h62;

  typedef enum logic [1:0] {OP_START, OP_TERM_MSA, OP_TERM_CSA} scm_op_t;

  // Selection byte to code 1..4 (b1 b2 b3 b8); 0 otherwise
  function automatic logic [2:0] scm_sel_code(input logic [7:0] sel);
    case (sel)
      8'h01:   scm_sel_code = 3'h1;
      8'h02:   scm_sel_code = 3'h2;
      8'h04:   scm_sel_code = 3'h3;
      8'h80:   scm_sel_code = 3'h4;
      default: scm_sel_code = 3'h0;
    endcase
  endfunction

endpackage

// ===== core/scm_byte_tx.sv
// Purpose: One-byte holding stage toward the card link
// Assumes: Card takes a byte when tx_valid and tx_ready are both high
// Notes:   Accepts a new byte only when the stage is empty
`timescale 1ns/1ps
module scm_byte_tx
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output logic            in_ready,
  output logic [7:0]      tx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready
);
  import scm_pkg::*;

  assign in_ready = !tx_valid;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_valid <= 1'b0;
      tx_data  <= BYTE_RST;
    end
    else if (in_valid && in_ready)
    begin
      tx_valid <= 1'b1;
      tx_data  <= in_data;
    end
    else if (tx_valid && tx_ready)
    begin
      tx_valid <= 1'b0;
    end
  end
endmodule

// ===== core/scm_byte_rx.sv
// Purpose: Collects the last five bytes returned by the card
// Assumes: One byte per cycle in which rx_valid is high
// Notes:   Newest byte sits in the low lane; count saturates at five
`timescale 1ns/1ps
module scm_byte_rx
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic [39:0]      bytes,
  output logic [2:0]       count
);
  import scm_pkg::*;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bytes <= 40'h00_0000_0000;
      count <= 3'h0;
    end
    else if (clr)
    begin
      bytes <= 40'h00_0000_0000;
      count <= 3'h0;
    end
    else if (rx_valid)
    begin
      bytes <= {bytes[31:0], rx_data};
      if (count != 3'h5)
      begin
        count <= count + 3'h1;
      end
    end
  end
endmodule

// ===== core/scm_host_ctrl.sv
// Purpose: Terminal-side controller issuing secure-channel start and terminate commands
// Assumes: Card answers on the byte link; software drives it over Wishbone
// Notes:   Rules follow
`timescale 1ns/1ps
module scm_host_ctrl
#(
  parameter int MAX_OBJ = 3
)
(
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [scm_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [3:0]              wb_sel_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  output logic      [7:0]              card_tx_data,
  output logic                         card_tx_valid,
  input  wire logic                    card_tx_ready,
  input  wire logic [7:0]              card_rx_data,
  input  wire logic                    card_rx_valid
);
  import scm_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_CMD_SW, ST_FETCH, ST_FETCH_RSP} scm_state_t;

  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  scm_state_t  state_reg;
  logic [7:0]  idx_reg;
  logic [7:0]  cla_reg;
  logic [7:0]  ins_reg;
  logic [7:0]  cipher_select_byte;
  logic [7:0]  integrity_select_byte;
  logic [7:0]  size_reg;
  logic [7:0]  max_size_reg;
  scm_op_t     op_reg;
  logic [1:0]  cnt_reg;
  logic [7:0]  obj_buf [0:MAX_OBJ*OBJ_BYTES-1];
  logic [7:0]  sess_size_reg [0:3];
  logic [1:0]  session_reg;
  logic [7:0]  sw1_reg;
  logic [7:0]  sw2_reg;
  logic        done_reg;
  logic        err_param_reg;
  logic        err_card_reg;
  logic        mac_fail_reg;
  logic        err_rsp_reg;
  logic        ack_reg;
  logic [31:0] rd_reg;
  logic        bus_req;
  logic        bus_wr;
  logic        go;
  logic        param_bad;
  logic [1:0]  obj_cnt;
  logic [7:0]  body_len;
  logic [7:0]  frame_len;
  logic        sending;
  logic        tx_in_valid;
  logic [7:0]  tx_in_data;
  logic        tx_in_ready;
  logic        rx_clr;
  logic [39:0] rx_bytes;
  logic [2:0]  rx_count;
  logic [31:0] rd_next;
  logic [2:0]  cipher_code;
  logic [2:0]  integ_code;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign bus_wr  = bus_req && wb_we_i;
  assign go      = bus_wr && wb_sel_i[0] && (wb_adr_i == ADR_CTRL) && wb_dat_i[0] && (state_reg == ST_IDLE);

  assign cipher_code = scm_sel_code(cipher_select_byte);
  assign integ_code  = scm_sel_code(integrity_select_byte);

  // Checks on the orders before any frame leaves
  always_comb
  begin
    param_bad = 1'b0;
    if (scm_op_t'(wb_dat_i[2:1]) == OP_START)
    begin
      if (cla_reg[1:0] != 2'b00)
        param_bad = 1'b1;
      if (cipher_code == 3'h0 || integ_code == 3'h0)
        param_bad = 1'b1;
      if (size_reg > max_size_reg)
        param_bad = 1'b1;
    end
    else if (scm_op_t'(wb_dat_i[2:1]) == OP_TERM_CSA)
    begin
      if (wb_dat_i[4:3] == 2'b00 || int'(wb_dat_i[4:3]) > MAX_OBJ)
        param_bad = 1'b1;
    end
    else if (scm_op_t'(wb_dat_i[2:1]) != OP_TERM_MSA)
    begin
      param_bad = 1'b1;
    end
  end

  // Configuration registers and object buffer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cla_reg               <= CLA_RST;
      ins_reg               <= INS_RST;
      cipher_select_byte    <= BYTE_RST;
      integrity_select_byte <= BYTE_RST;
      size_reg              <= BYTE_RST;
      max_size_reg          <= BYTE_RST;
    end
    else if (bus_wr && state_reg == ST_IDLE)
    begin
      if (wb_adr_i == ADR_ALG)
      begin
        if (wb_sel_i[0])
          cipher_select_byte <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          integrity_select_byte <= wb_dat_i[15:8];
      end
      if (wb_adr_i == ADR_SIZE)
      begin
        if (wb_sel_i[0])
          size_reg <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          max_size_reg <= wb_dat_i[15:8];
      end
      if (wb_adr_i == ADR_CLA_INS)
      begin
        if (wb_sel_i[0])
          cla_reg <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          ins_reg <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (bus_wr && state_reg == ST_IDLE && wb_adr_i >= ADR_BUF &&
        int'(wb_adr_i - ADR_BUF) < MAX_OBJ*OBJ_BYTES)
    begin
      for (int l = 0; l < 4; l++)
      begin
        if (wb_sel_i[l])
          obj_buf[int'(wb_adr_i - ADR_BUF) + l] <= wb_dat_i[8*l +: 8];
      end
    end
  end

  // Frame lengths
  assign obj_cnt   = (op_reg == OP_TERM_CSA) ? cnt_reg : 2'h1;
  assign body_len  = (op_reg == OP_START) ? START_BODY : 8'(OBJ_TLV * int'(obj_cnt));
  assign frame_len = (state_reg == ST_CMD) ? 8'(int'(body_len) + HDR_BYTES) : FETCH_LEN;

  function automatic logic [7:0] cmd_byte(input logic [7:0] idx);
    int b;
    int k;
    int r;
    b = int'(idx) - HDR_BYTES;
    k = 0;
    r = 0;
    cmd_byte = 8'h00;
    case (idx)
      8'h00: cmd_byte = cla_reg;
      8'h01: cmd_byte = ins_reg;
      8'h02: cmd_byte = (op_reg == OP_START) ? P1_START : P1_TERM;
      8'h03: cmd_byte = P2_CMD;
      8'h04: cmd_byte = 8'(int'(body_len) + 2);
      8'h05: cmd_byte = TAG_CMD;
      8'h06: cmd_byte = body_len;
      default:
      begin
        if (op_reg == OP_START)
        begin
          // Objects 89, 8B, 8D, 8E in order
          if (b == 0)
            cmd_byte = TAG_ALG;
          else if (b == 1)
            cmd_byte = LEN_ALG;
          else if (b == 2)
            cmd_byte = cipher_select_byte;
          else if (b == 3)
            cmd_byte = integrity_select_byte;
          else if (b == 4)
            cmd_byte = TAG_CSA;
          else if (b == 5 || b == 23)
            cmd_byte = LEN_ID;
          else if (b < 22)
            cmd_byte = obj_buf[b - 6];
          else if (b == 22)
            cmd_byte = TAG_MAC;
          else if (b < 40)
            cmd_byte = obj_buf[b - 24 + ID_BYTES];
          else if (b == 40)
            cmd_byte = TAG_SIZE;
          else if (b == 41)
            cmd_byte = LEN_SIZE;
          else
            cmd_byte = size_reg;
        end
        else
        begin
          k = b / OBJ_TLV;
          r = b - k * OBJ_TLV;
          if (r == 0)
            cmd_byte = (op_reg == OP_TERM_MSA) ? TAG_MSA : TAG_CSA;
          else if (r == 1)
            cmd_byte = LEN_OBJ;
          else
            cmd_byte = obj_buf[k * OBJ_BYTES + r - 2];
        end
      end
    endcase
  endfunction

  function automatic logic [7:0] fetch_byte(input logic [7:0] idx);
    case (idx)
      8'h00:   fetch_byte = cla_reg;
      8'h01:   fetch_byte = ins_reg;
      8'h02:   fetch_byte = P1_START;
      8'h03:   fetch_byte = P2_RSP;
      default: fetch_byte = START_RSP_LE;
    endcase
  endfunction

  assign sending     = (state_reg == ST_CMD) || (state_reg == ST_FETCH);
  assign tx_in_valid = sending && (idx_reg < frame_len);
  assign tx_in_data  = (state_reg == ST_CMD) ? cmd_byte(idx_reg) : fetch_byte(idx_reg);
  assign rx_clr      = go || (state_reg == ST_CMD_SW && rx_count >= 3'h2);

  scm_byte_tx u_tx
  (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .in_valid (tx_in_valid),
    .in_data  (tx_in_data),
    .in_ready (tx_in_ready),
    .tx_data  (card_tx_data),
    .tx_valid (card_tx_valid),
    .tx_ready (card_tx_ready)
  );

  scm_byte_rx u_rx
  (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .clr      (rx_clr),
    .rx_valid (card_rx_valid),
    .rx_data  (card_rx_data),
    .bytes    (rx_bytes),
    .count    (rx_count)
  );

  // Sequencer and result flags
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= ST_IDLE;
      idx_reg       <= 8'h00;
      op_reg        <= OP_START;
      cnt_reg       <= 2'h0;
      session_reg   <= 2'h0;
      sw1_reg       <= 8'h00;
      sw2_reg       <= 8'h00;
      done_reg      <= 1'b0;
      err_param_reg <= 1'b0;
      err_card_reg  <= 1'b0;
      mac_fail_reg  <= 1'b0;
      err_rsp_reg   <= 1'b0;
      for (int s = 0; s < 4; s++)
        sess_size_reg[s] <= 8'h00;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (go)
          begin
            op_reg        <= scm_op_t'(wb_dat_i[2:1]);
            cnt_reg       <= wb_dat_i[4:3];
            idx_reg       <= 8'h00;
            done_reg      <= param_bad;
            err_param_reg <= param_bad;
            err_card_reg  <= 1'b0;
            mac_fail_reg  <= 1'b0;
            err_rsp_reg   <= 1'b0;
            if (!param_bad)
              state_reg <= ST_CMD;
          end
        end
        ST_CMD, ST_FETCH:
        begin
          if (tx_in_valid && tx_in_ready)
            idx_reg <= idx_reg + 8'h01;
          else if (idx_reg == frame_len && tx_in_ready)
            state_reg <= (state_reg == ST_CMD) ? ST_CMD_SW : ST_FETCH_RSP;
        end
        ST_CMD_SW:
        begin
          if (rx_count >= 3'h2)
          begin
            sw1_reg <= rx_bytes[15:8];
            sw2_reg <= rx_bytes[7:0];
            idx_reg <= 8'h00;
            if (rx_bytes[15:0] == {SW1_OK, SW2_OK})
            begin
              if (op_reg == OP_START)
                state_reg <= ST_FETCH;
              else
              begin
                state_reg <= ST_IDLE;
                done_reg  <= 1'b1;
              end
            end
            else
            begin
              state_reg    <= ST_IDLE;
              done_reg     <= 1'b1;
              err_card_reg <= 1'b1;
              mac_fail_reg <= (op_reg != OP_START) && (rx_bytes[15:0] == {SW1_MAC_BAD, SW2_MAC_BAD});
            end
          end
        end
        ST_FETCH_RSP:
        begin
          if (rx_count == 3'h5)
          begin
            state_reg <= ST_IDLE;
            done_reg  <= 1'b1;
            sw1_reg   <= rx_bytes[15:8];
            sw2_reg   <= rx_bytes[7:0];
            if (rx_bytes[15:0] != {SW1_OK, SW2_OK})
              err_card_reg <= 1'b1;
            else if (rx_bytes[39:32] != TAG_START_RSP || rx_bytes[31:24] != START_RSP_LEN ||
                     rx_bytes[21:16] != 6'h00)
              err_rsp_reg <= 1'b1;
            else
            begin
              session_reg                         <= rx_bytes[23:22];
              sess_size_reg[rx_bytes[23:22]]      <= size_reg;
            end
          end
        end
      endcase
    end
  end

  // Register read-back
  always_comb
  begin
    rd_next = 32'h0000_0000;
    if (wb_adr_i == ADR_CTRL)
      rd_next = {27'h000_0000, cnt_reg, op_reg, 1'b0};
    else if (wb_adr_i == ADR_STATUS)
      rd_next = {2'b00, integ_code, cipher_code, sw1_reg, sw2_reg, session_reg, err_rsp_reg, mac_fail_reg,
                 err_card_reg, err_param_reg, done_reg, (state_reg != ST_IDLE)};
    else if (wb_adr_i == ADR_ALG)
      rd_next = {16'h0000, integrity_select_byte, cipher_select_byte};
    else if (wb_adr_i == ADR_SIZE)
      rd_next = {16'h0000, max_size_reg, size_reg};
    else if (wb_adr_i == ADR_CLA_INS)
      rd_next = {16'h0000, ins_reg, cla_reg};
    else if (wb_adr_i == ADR_SESS)
      rd_next = {sess_size_reg[3], sess_size_reg[2], sess_size_reg[1], sess_size_reg[0]};
    else if (wb_adr_i >= ADR_BUF && int'(wb_adr_i - ADR_BUF) < MAX_OBJ*OBJ_BYTES)
    begin
      for (int l = 0; l < 4; l++)
        rd_next[8*l +: 8] = obj_buf[int'({wb_adr_i[ADR_W-1:2], 2'b00} - ADR_BUF) + l];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      rd_reg  <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= bus_req;
      if (bus_req)
        rd_reg <= rd_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;
endmodule

// ===== verif/scm_host_ctrl_chk.sv
// Purpose: Port-level checks of the terminal controller
// Assumes: Card link bytes are counted from the last response byte
// Notes:   Attached by bind from the bench top file
`timescale 1ns/1ps
module scm_host_ctrl_chk
  import scm_pkg::*;
(
  input wire logic                        ref_clk,
  input wire logic                        rstn,
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_we_i,
  input wire logic [scm_pkg::ADR_W-1:0]   wb_adr_i,
  input wire logic [31:0]                 wb_dat_i,
  input wire logic [3:0]                  wb_sel_i,
  input wire logic [31:0]                 wb_dat_o,
  input wire logic                        wb_ack_o,
  input wire logic [7:0]                  card_tx_data,
  input wire logic                        card_tx_valid,
  input wire logic                        card_tx_ready,
  input wire logic [7:0]                  card_rx_data,
  input wire logic                        card_rx_valid
);
  logic [7:0] pos_reg;
  logic [7:0] cla_reg;
  logic [7:0] p2_reg;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // Byte position inside the current frame
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pos_reg <= 8'h00;
      cla_reg <= 8'h00;
      p2_reg  <= 8'h00;
    end
    else if (card_rx_valid)
      pos_reg <= 8'h00;
    else if (card_tx_valid && card_tx_ready)
    begin
      pos_reg <= pos_reg + 8'h01;
      if (pos_reg == 8'h00)
        cla_reg <= card_tx_data;
      if (pos_reg == 8'h03)
        p2_reg <= card_tx_data;
    end
  end

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_take;
    card_tx_valid && card_tx_ready;
  endsequence

  ack_timing_a: assert property (s_req |=> wb_ack_o) else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  tx_hold_a: assert property (card_tx_valid && !card_tx_ready |=> card_tx_valid && $stable(card_tx_data))
    else $error("tx byte dropped");
  tx_gap_a: assert property (s_take |=> !card_tx_valid) else $error("tx no gap");
  p1_code_a: assert property (s_take ##0 (pos_reg == 8'h02) |-> card_tx_data inside {P1_START, P1_TERM})
    else $error("bad p1");
  p2_code_a: assert property (s_take ##0 (pos_reg == 8'h03) |-> card_tx_data inside {P2_CMD, P2_RSP})
    else $error("bad p2");
  start_chan_a: assert property (s_take ##0 (pos_reg == 8'h02 && card_tx_data == P1_START) |-> cla_reg[1:0] == 2'b00)
    else $error("start off channel 0");
  cmd_tag_a: assert property (s_take ##0 (pos_reg == 8'h05 && p2_reg == P2_CMD) |-> card_tx_data == TAG_CMD)
    else $error("bad data tag");
  fetch_le_a: assert property (s_take ##0 (pos_reg == 8'h04 && p2_reg == P2_RSP) |-> card_tx_data == START_RSP_LE)
    else $error("bad fetch length");
endmodule

// ===== verif/scm_card_model.sv
// Purpose: Behavioural card answering command and fetch frames
// Assumes: Frames are CLA INS P1 P2 then Lc and data, or Le alone
// Notes:   Logs every byte taken; slow mode stalls ready and spaces replies
`timescale 1ns/1ps
module scm_card_model
  import scm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       slow,
  input  wire logic [7:0] sw1,
  input  wire logic [7:0] sw2,
  input  wire logic [1:0] sess,
  input  wire logic [7:0] rsp_low
);
  logic [7:0] log_b [0:1023];
  logic [7:0] p1;
  logic [7:0] p2;
  logic [7:0] lc;
  logic [7:0] rq [$];
  int         nlog = 0;
  int         pos = 0;

  initial
  begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end

  always @(posedge clk)
  begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready)
    begin
      log_b[nlog] = tx_data;
      nlog++;
      if (pos == 2) p1 = tx_data;
      if (pos == 3) p2 = tx_data;
      if (pos == 4) lc = tx_data;
      pos++;
      if (pos >= 5 && (p2 == P2_RSP || pos == 5 + lc))
      begin
        pos = 0;
        if (p2 == P2_RSP)
          rq = {TAG_START_RSP, START_RSP_LEN, {sess, 6'h00} | rsp_low, sw1, sw2};
        else if (p1 == P1_START)
          rq = {SW1_OK, SW2_OK};
        else
          rq = {sw1, sw2};
      end
    end
    if (rq.size() > 0 && !(slow && rx_valid))
    begin
      rx_valid <= 1'b1;
      rx_data <= rq.pop_front();
    end
    else
    begin
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
    end
  end
endmodule

// ===== verif/tb_scm_host_ctrl.sv
// Purpose: Self-checking bench for the terminal controller
// Assumes: Card model answers every frame it is sent
// Notes:   Random values come from a fixed xorshift seed
`timescale 1ns/1ps
module tb_scm_host_ctrl;
  import scm_pkg::*;
  typedef logic [7:0] scm_bq_t [$];
  logic             ref_clk = 1'b0;
  logic             rstn = 1'b0;
  logic             wb_cyc_i = 1'b0;
  logic             wb_stb_i = 1'b0;
  logic             wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [31:0]      wb_dat_i = '0;
  logic [3:0]       wb_sel_i = 4'hF;
  logic [31:0]      wb_dat_o;
  logic             wb_ack_o;
  logic [7:0]       card_tx_data;
  logic             card_tx_valid;
  logic             card_tx_ready;
  logic [7:0]       card_rx_data;
  logic             card_rx_valid;
  logic             slow = 1'b0;
  logic [7:0]       sw1 = SW1_OK;
  logic [7:0]       sw2 = SW2_OK;
  logic [7:0]       rsp_low = 8'h00;
  logic [1:0]       sess = 2'h0;
  logic [31:0]      seed = 32'h0000005A;
  logic [31:0]      rd;
  logic [7:0]       ins;
  logic [7:0]       buf_b [0:95];
  logic [7:0]       sel_tab [0:3] = '{8'h01, 8'h02, 8'h04, 8'h80};
  logic [15:0]      sw_tab [0:3] = '{16'h9862, 16'h9000, 16'h6A88, 16'h9000};
  int               failures = 0;
  int               n_tests = 0;
  int               base;

  scm_host_ctrl #(.MAX_OBJ(3)) uut (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .card_tx_data(card_tx_data), .card_tx_valid(card_tx_valid),
    .card_tx_ready(card_tx_ready), .card_rx_data(card_rx_data), .card_rx_valid(card_rx_valid));
  scm_card_model card (.clk(ref_clk), .tx_data(card_tx_data), .tx_valid(card_tx_valid), .tx_ready(card_tx_ready),
    .rx_data(card_rx_data), .rx_valid(card_rx_valid), .slow(slow), .sw1(sw1), .sw2(sw2), .sess(sess),
    .rsp_low(rsp_low));

  always #5 ref_clk = ~ref_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic scm_bq_t exp_frame(input scm_op_t op, input int n, input logic [7:0] cla, ca, ia, sz);
    scm_bq_t q;
    if (op == OP_START)
    begin
      q = {cla, ins, P1_START, P2_CMD, START_BODY + 8'h02, TAG_CMD, START_BODY, TAG_ALG, LEN_ALG, ca, ia, TAG_CSA, LEN_ID};
      for (int k = 0; k < 32; k++)
      begin
        if (k == 16)
          q = {q, TAG_MAC, LEN_ID};
        q = {q, buf_b[k]};
      end
      q = {q, TAG_SIZE, LEN_SIZE, sz, cla, ins, P1_START, P2_RSP, START_RSP_LE};
    end
    else
    begin
      q = {cla, ins, P1_TERM, P2_CMD, 8'(OBJ_TLV * n + 2), TAG_CMD, 8'(OBJ_TLV * n)};
      for (int k = 0; k < OBJ_BYTES * n; k++)
      begin
        if (k % OBJ_BYTES == 0)
          q = {q, (op == OP_TERM_MSA) ? TAG_MSA : TAG_CSA, LEN_OBJ};
        q = {q, buf_b[k]};
      end
    end
    return q;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic setup(input logic [7:0] cla, ca, ia, sz, mx);
    ins = 8'(rnd());
    wb(1'b1, ADR_ALG, {16'h0000, ia, 8'hFF}, 4'h3);
    wb(1'b1, ADR_ALG, {24'h000000, ca}, 4'h1);
    wb(1'b1, ADR_SIZE, {16'h0000, mx, sz}, 4'hF);
    wb(1'b1, ADR_CLA_INS, {16'h0000, ins, cla}, 4'hF);
  endtask

  task automatic run(input scm_op_t op, input logic [1:0] cnt);
    base = card.nlog;
    wb(1'b1, ADR_CTRL, {27'h0000000, cnt, op, 1'b1}, 4'hF);
    do wb(1'b0, ADR_STATUS, '0, 4'hF); while (rd[0] !== 1'b0);
  endtask

  task automatic chk_frame(input scm_bq_t q);
    chk("frame_len", 32'(q.size()), 32'(card.nlog - base));
    for (int k = 0; k < q.size(); k++)
      chk("frame_byte", {24'h000000, q[k]}, {24'h000000, card.log_b[base + k]});
  endtask

  task automatic test_done();
    if (failures == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    failures++;
    test_done();
  end

  initial
  begin
    logic [7:0] cla;
    logic [7:0] sz;
    logic [7:0] mx;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wb(1'b0, ADR_STATUS, '0, 4'hF);
    chk("status_rst", 32'h00000000, rd);
    wb(1'b1, 9'h0F0, 32'hFFFFFFFF, 4'hF);
    wb(1'b0, 9'h0F0, '0, 4'hF);
    chk("unmapped", 32'h00000000, rd);
    for (int k = 0; k < 96; k++)
      buf_b[k] = 8'(rnd());
    for (int k = 0; k < 24; k++)
      wb(1'b1, ADR_BUF + 9'(4 * k), {buf_b[4*k+3], buf_b[4*k+2], buf_b[4*k+1], buf_b[4*k]}, 4'hF);
    for (int i = 0; i < 4; i++)
    begin
      mx = 8'(rnd()) | 8'h01;
      sz = (i == 0) ? mx : 8'(rnd()) % mx;
      cla = 8'(rnd()) & 8'hFC;
      sess <= 2'(i);
      slow <= i[0];
      setup(cla, sel_tab[i], sel_tab[(i + 1) % 4], sz, mx);
      run(OP_START, 2'h0);
      chk("status_start", {2'b00, 3'((i + 1) % 4 + 1), 3'(i + 1), SW1_OK, SW2_OK, 2'(i), 6'h02}, rd);
      chk_frame(exp_frame(OP_START, 1, cla, sel_tab[i], sel_tab[(i + 1) % 4], sz));
      wb(1'b0, ADR_SESS, '0, 4'hF);
      chk("sess_size", {24'h000000, sz}, {24'h000000, rd[8*i +: 8]});
    end
    for (int j = 0; j < 4; j++)
    begin
      setup(j == 0 ? 8'h01 : 8'h00, j == 1 ? 8'h03 : 8'h04, j == 2 ? 8'h00 : 8'h01, j == 3 ? 8'h41 : 8'h10, 8'h40);
      run(OP_START, 2'h0);
      chk("param_err", 32'h00000004, rd & 32'h00000005);
      chk("param_tx", 32'(base), 32'(card.nlog));
    end
    setup(8'h00, 8'h02, 8'h04, 8'h10, 8'h40);
    rsp_low <= 8'h01;
    run(OP_START, 2'h0);
    chk("rsp_low", 32'h00000020, rd & 32'h00000020);
    rsp_low <= 8'h00;
    for (int t = 0; t < 4; t++)
    begin
      {sw1, sw2} <= sw_tab[t];
      slow <= t[0];
      cla = 8'(rnd());
      setup(cla, 8'h01, 8'h01, 8'h10, 8'h40);
      run(t == 0 ? OP_TERM_MSA : OP_TERM_CSA, 2'(t == 0 ? 1 : t));
      chk("status_term", {8'h00, sw_tab[t], 3'b000, sw_tab[t] == 16'h9862, sw_tab[t] != 16'h9000, 3'b010},
          rd & 32'h00FFFF3F);
      chk_frame(exp_frame(t == 0 ? OP_TERM_MSA : OP_TERM_CSA, t == 0 ? 1 : t, cla, 8'h01, 8'h01, 8'h10));
    end
    wb(1'b0, ADR_CTRL, '0, 4'hF);
    chk("ctrl_rd", 32'h0000001C, rd);
    run(OP_TERM_CSA, 2'h0);
    chk("cnt_zero", 32'h00000004, rd & 32'h00000005);
    test_done();
  end
endmodule

bind scm_host_ctrl scm_host_ctrl_chk chk_i (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .card_tx_data(card_tx_data), .card_tx_valid(card_tx_valid), .card_tx_ready(card_tx_ready),
  .card_rx_data(card_rx_data), .card_rx_valid(card_rx_valid));
